// [rtl/lvd_top.sv]
// eight-line programmable video line delay with blanking and broadcast
//
// Functional notes
// R1 - eight 8-bit lines, 12 to 516 stages
// R2 - wide stages equal four times count plus eight
// R3 - zero count is illegal, never loaded
// R4 - count latch follows input while enable low
// R5 - narrow mode cascades pairs, four outputs
// R6 - narrow stages equal eight times count plus sixteen
// R7 - output blanking forces all outputs zero
// R8 - input blanking replaces incoming data with zero
// R9 - broadcast feeds first input to all lines
// R10 - each line delays exactly programmed stage count
// R11 - software sets stages to pixels per line
`timescale 1ns/1ps
module lvd_top
  import lvd_pkg::*;
#(
  parameter int NUM_LINES = LVD_NUM_LINES,
  parameter int DW = LVD_DW,
  parameter int DEPTH = LVD_MAX_STAGES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // register port
  input wire logic [LVD_AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // delay count latch
  input wire logic [LVD_CW-1:0] i_cnt,
  input wire logic i_cnt_we_n,
  // blanking
  input wire logic i_blank_in,
  input wire logic i_blank_out,
  // pixel streams
  input wire logic [NUM_LINES-1:0][DW-1:0] i_data,
  output logic [NUM_LINES-1:0][DW-1:0] o_data
);
  // ********************
  // configuration state
  // ********************
  logic [LVD_CW-1:0] cnt_ff;
  logic [LVD_CW-1:0] nxt_cnt;
  lvd_ctrl_t ctrl_ff;
  lvd_ctrl_t nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [LVD_LW-1:0] stage_len;

  // synchronous stand-in for the transparent latch; zero keeps the old count
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!i_cnt_we_n && i_cnt != '0) begin // R3
      nxt_cnt = i_cnt; // R4
    end
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rdata = '0;
    if (i_wr && i_addr == LVD_OFF_CTRL) begin
      nxt_ctrl.narrow = i_wdata[LVD_CTRL_NARROW_BIT];
      nxt_ctrl.broadcast = i_wdata[LVD_CTRL_BCAST_BIT];
    end
    if (i_rd) begin
      unique case (i_addr)
        LVD_OFF_CTRL: begin
          nxt_rdata[LVD_CTRL_NARROW_BIT] = ctrl_ff.narrow;
          nxt_rdata[LVD_CTRL_BCAST_BIT] = ctrl_ff.broadcast;
        end
        LVD_OFF_STAT: begin
          nxt_rdata[LVD_STAT_CNT_LSB +: LVD_CW] = cnt_ff;
          nxt_rdata[LVD_STAT_LEN_LSB +: LVD_LW] = stage_len;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= LVD_CNT_RST;
      ctrl_ff <= LVD_CTRL_RST;
      rdata_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // per-line stage count; a narrow pair spans twice this
  assign stage_len = LVD_LW'(cnt_ff) * LVD_STAGE_MUL + LVD_STAGE_ADD; // R2 R6

  // ********************
  // delay lines
  // ********************
  logic [NUM_LINES-1:0][DW-1:0] line_in;
  logic [NUM_LINES-1:0][DW-1:0] line_out;
  logic [NUM_LINES-1:0][DW-1:0] out_ff;
  logic [NUM_LINES-1:0][DW-1:0] nxt_out;

  // ring is two short of the stage count: the output flop and the
  // read register each add one cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      logic [LVD_LW-1:0] ring_len;
      logic [DW-1:0] src;
      always_comb begin
        if (ctrl_ff.broadcast) begin
          src = i_data[0]; // R9
        end else begin
          src = i_data[gi];
        end
        if (i_blank_in) begin
          src = '0; // R8
        end
        ring_len = stage_len - LVD_LW'(2); // R1 R10
        if (ctrl_ff.narrow && (gi % 2 == 1)) begin
          // second half of a pair takes the first half's output directly
          // even partner index, kept in range for the even lines too
          src = line_out[(gi / 2) * 2]; // R5
          ring_len = stage_len - LVD_LW'(1); // R6
        end
        line_in[gi] = src;
        if (ctrl_ff.narrow && (gi % 2 == 0)) begin
          nxt_out[gi] = '0; // R5
        end else begin
          nxt_out[gi] = line_out[gi];
        end
        if (i_blank_out) begin
          nxt_out[gi] = '0; // R7
        end
      end
      lvd_ring #(.DEPTH(DEPTH), .AW(LVD_LW), .W(DW)) u_ring (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_len(ring_len),
        .i_din(line_in[gi]),
        .o_dout(line_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign o_data = out_ff;

  // ********************
  // checks
  // ********************
  logic [4:0] stable_ff;
  logic [4:0] nxt_stable;

  always_comb begin
    nxt_stable = stable_ff;
    if (nxt_cnt != cnt_ff || nxt_ctrl != ctrl_ff) begin
      nxt_stable = '0;
    end else if (stable_ff != 5'h1f) begin
      nxt_stable = stable_ff + 5'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stable_ff <= '0;
    end else begin
      stable_ff <= nxt_stable;
    end
  end

  property p_stage_range;
    @(posedge i_mclk) disable iff (!i_resetn)
      stage_len >= LVD_LW'(LVD_MIN_STAGES) && stage_len <= LVD_LW'(DEPTH);
  endproperty
  a_stage_range: assert property (p_stage_range) else $error("stage count out of range"); // R1

  property p_stage_eq;
    @(posedge i_mclk) disable iff (!i_resetn)
      stage_len == LVD_LW'({cnt_ff, 2'b00}) + LVD_LW'(8);
  endproperty
  a_stage_eq: assert property (p_stage_eq) else $error("stage count formula wrong"); // R2

  property p_zero_refused;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!i_cnt_we_n && i_cnt == '0) |=> $stable(cnt_ff) && cnt_ff != '0;
  endproperty
  a_zero_refused: assert property (p_zero_refused) else $error("zero count loaded"); // R3

  sequence s_cnt_write;
    !i_cnt_we_n && i_cnt != '0;
  endsequence
  property p_latch;
    @(posedge i_mclk) disable iff (!i_resetn)
      (s_cnt_write |=> cnt_ff == $past(i_cnt)) and (i_cnt_we_n |=> $stable(cnt_ff));
  endproperty
  a_latch: assert property (p_latch) else $error("count latch misbehaves"); // R4

  property p_narrow_even;
    @(posedge i_mclk) disable iff (!i_resetn)
      ctrl_ff.narrow |=> o_data[0] == '0 && o_data[2] == '0;
  endproperty
  a_narrow_even: assert property (p_narrow_even) else $error("unused narrow output not zero"); // R5

  property p_blank_out;
    @(posedge i_mclk) disable iff (!i_resetn)
      i_blank_out |=> o_data == '0;
  endproperty
  a_blank_out: assert property (p_blank_out) else $error("outputs not blanked"); // R7

  property p_blank_in;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_blank_in && !ctrl_ff.narrow) |-> line_in == '0;
  endproperty
  a_blank_in: assert property (p_blank_in) else $error("inputs not blanked"); // R8

  property p_bcast;
    @(posedge i_mclk) disable iff (!i_resetn)
      (ctrl_ff.broadcast && !ctrl_ff.narrow && !i_blank_in) |->
        line_in[NUM_LINES-1] == i_data[0] && line_in[1] == i_data[0];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast data mismatch"); // R9

  sequence s_min_settled;
    stable_ff >= 5'h10 && cnt_ff == 7'h01 && !$past(i_blank_out);
  endsequence
  property p_wide_delay;
    @(posedge i_mclk) disable iff (!i_resetn)
      (s_min_settled and !ctrl_ff.narrow) |-> o_data[1] == $past(line_in[1], 12);
  endproperty
  a_wide_delay: assert property (p_wide_delay) else $error("wide delay not twelve"); // R10

  // a pair needs both rings refilled after a change, so wait longer
  property p_narrow_delay;
    @(posedge i_mclk) disable iff (!i_resetn)
      (s_min_settled and stable_ff >= 5'h1c && ctrl_ff.narrow) |->
        o_data[1] == $past(line_in[0], 24);
  endproperty
  a_narrow_delay: assert property (p_narrow_delay) else $error("narrow delay not 24"); // R6
endmodule

// [rtl/lvd_pkg.sv]
// constants and types shared by the video line delay
package lvd_pkg;
  // ********************
  // geometry
  // ********************
  localparam int LVD_NUM_LINES = 8;
  localparam int LVD_DW = 8;
  localparam int LVD_CW = 7;
  localparam int LVD_LW = 10;
  localparam int LVD_MAX_STAGES = 516;
  localparam int LVD_MIN_STAGES = 12;
  localparam logic [9:0] LVD_STAGE_MUL = 10'h004;
  localparam logic [9:0] LVD_STAGE_ADD = 10'h008;
  localparam logic [6:0] LVD_CNT_RST = 7'h01;
  // ********************
  // register map
  // ********************
  localparam int LVD_AW = 8;
  localparam logic [7:0] LVD_OFF_CTRL = 8'h00;
  localparam logic [7:0] LVD_OFF_STAT = 8'h04;
  localparam int LVD_CTRL_NARROW_BIT = 0;
  localparam int LVD_CTRL_BCAST_BIT = 1;
  localparam int LVD_STAT_CNT_LSB = 0;
  localparam int LVD_STAT_LEN_LSB = 16;
  typedef struct packed {
    logic broadcast;
    logic narrow;
  } lvd_ctrl_t;
  localparam lvd_ctrl_t LVD_CTRL_RST = '{broadcast: 1'b0, narrow: 1'b0};
endpackage

// [rtl/lvd_ring.sv]
// one variable-length delay line held in a circular array
`timescale 1ns/1ps
module lvd_ring
  import lvd_pkg::*;
#(
  parameter int DEPTH = LVD_MAX_STAGES,
  parameter int AW = LVD_LW,
  parameter int W = LVD_DW
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // ring length in cycles, at least 2
  input wire logic [AW-1:0] i_len,
  // data
  input wire logic [W-1:0] i_din,
  output logic [W-1:0] o_dout
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] nxt_wp;
  logic [W-1:0] dout_ff;

  // shrinking the length mid-line must not strand the pointer past the end
  always_comb begin
    if (wp_ff >= i_len - AW'(1)) begin
      nxt_wp = '0;
    end else begin
      nxt_wp = wp_ff + AW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
    end
  end

  // read-before-write gives i_len cycles in the array; dout_ff adds one more, so o_dout lags i_din by i_len + 1
  always_ff @(posedge i_mclk) begin
    mem[wp_ff] <= i_din; // R10
    dout_ff <= mem[wp_ff];
  end

  assign o_dout = dout_ff;
endmodule

// [testbench/lvd_pix_src.sv]
// raster pixel source model feeding the line delay
`timescale 1ns/1ps
module lvd_pix_src
  import lvd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // line length and blanking requests
  input wire logic [LVD_LW-1:0] i_len,
  input wire logic i_hblank_en,
  input wire logic i_vblank,
  // stream to the delay
  output logic [LVD_NUM_LINES-1:0][LVD_DW-1:0] o_data,
  output logic o_blank_in,
  output logic o_blank_out
);
  logic [LVD_LW-1:0] pix_ff, nxt_pix;
  logic [7:0] row_ff, nxt_row;
  // line wraps at i_len so a delay of i_len shows the pixel above
  always_comb begin
    nxt_pix = pix_ff + 10'h001;
    nxt_row = row_ff;
    if (pix_ff + 10'h001 >= i_len) begin
      nxt_pix = '0;
      nxt_row = row_ff + 8'h01;
    end
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pix_ff <= '0;
      row_ff <= '0;
    end else begin
      pix_ff <= nxt_pix;
      row_ff <= nxt_row;
    end
  end
  // words differ per line, pixel and row, so a wrong tap shows
  always_comb begin
    for (int i = 0; i < LVD_NUM_LINES; i++) begin
      o_data[i] = pix_ff[7:0] + row_ff + 8'(i * 29);
    end
  end
  // last two pixels of a line are horizontal blanking
  assign o_blank_out = i_hblank_en && (pix_ff + 10'h002 >= i_len);
  assign o_blank_in = i_vblank;
endmodule

// [testbench/lvd_top_test.sv]
// self-checking bench for the video line delay
`timescale 1ns/1ps
module lvd_top_test;
  import lvd_pkg::*;
  logic i_mclk, i_resetn, i_wr, i_rd, i_cnt_we_n, hb_en, vb, i_blank_in, i_blank_out, bo_q;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [6:0] i_cnt;
  logic [9:0] len;
  logic [7:0][7:0] i_data, o_data, eff, exp;
  logic [7:0][7:0] hist [4096];
  int mismatches, checks_done, cyc, settle, d, cnt_m, narrow_m, bcast_m;
  lvd_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cnt(i_cnt), .i_cnt_we_n(i_cnt_we_n),
    .i_blank_in(i_blank_in), .i_blank_out(i_blank_out), .i_data(i_data), .o_data(o_data));
  lvd_pix_src src (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_len(len), .i_hblank_en(hb_en),
    .i_vblank(vb), .o_data(i_data), .o_blank_in(i_blank_in), .o_blank_out(i_blank_out));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ********************
  // helpers
  // ********************
  task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 check("o_rdata", o_rdata, e);
  endtask
  // never loads zero; line length follows the stage count
  task automatic set_cnt(logic [6:0] c, logic [9:0] l);
    @(posedge i_mclk);
    i_cnt_we_n <= 1'b0;
    i_cnt <= c;
    len <= l;
    @(posedge i_mclk);
    i_cnt_we_n <= 1'b1;
  endtask
  function automatic logic [31:0] stat_v(int c);
    return (32'(4 * c + 8) << 16) | 32'(c);
  endfunction
  // ********************
  // output monitor
  // ********************
  // delay memory is not reset, so checks wait out two full passes
  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      settle = 0;
      cnt_m = 1;
      narrow_m = 0;
      bcast_m = 0;
    end else begin
      eff = i_blank_in ? '0 : i_data;
      if (bcast_m != 0) eff = {8{eff[0]}};
      d = narrow_m != 0 ? 8 * cnt_m + 16 : 4 * cnt_m + 8;
      if (settle > 2 * d + 4) begin
        for (int i = 0; i < 8; i++) begin
          exp[i] = hist[(cyc - d) & 4095][narrow_m != 0 ? i - i % 2 : i];
          if (bo_q || (narrow_m != 0 && i % 2 == 0)) exp[i] = 8'h00;
          check("o_data", 32'(o_data[i]), 32'(exp[i]));
        end
      end
      hist[cyc & 4095] = eff;
      cyc++;
      settle++;
      if (!i_cnt_we_n && i_cnt != 7'h00) begin
        cnt_m = i_cnt;
        settle = 0;
      end
      if (i_wr && i_addr == LVD_OFF_CTRL) begin
        narrow_m = i_wdata[0];
        bcast_m = i_wdata[1];
        settle = 0;
      end
    end
    bo_q = i_blank_out;
  end
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  // ********************
  // stimulus
  // ********************
  initial begin
    i_resetn = 1'b0;
    {i_wr, i_rd, hb_en, vb} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_cnt = 7'h01;
    i_cnt_we_n = 1'b1;
    len = 10'h00c;
    {mismatches, checks_done, cyc} = 0;
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd_chk(LVD_OFF_CTRL, 32'h0000_0000);
    rd_chk(LVD_OFF_STAT, stat_v(1));
    @(posedge i_mclk);
    #1 check("o_rdata", o_rdata, 32'h0000_0000);
    wr(8'h08, 32'h0000_0003);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(LVD_OFF_CTRL, 32'h0000_0000);
    repeat (60) @(posedge i_mclk);
    set_cnt(7'h05, 10'h01c);
    rd_chk(LVD_OFF_STAT, stat_v(5));
    i_cnt <= 7'h09;
    rd_chk(LVD_OFF_STAT, stat_v(5));
    hb_en <= 1'b1;
    repeat (100) @(posedge i_mclk);
    vb <= 1'b1;
    repeat (40) @(posedge i_mclk);
    vb <= 1'b0;
    set_cnt(7'h7f, 10'h204);
    rd_chk(LVD_OFF_STAT, stat_v(127));
    repeat (1100) @(posedge i_mclk);
    wr(LVD_OFF_CTRL, 32'h0000_0001);
    set_cnt(7'h02, 10'h020);
    repeat (90) @(posedge i_mclk);
    vb <= 1'b1;
    repeat (40) @(posedge i_mclk);
    vb <= 1'b0;
    wr(LVD_OFF_CTRL, 32'h0000_0002);
    rd_chk(LVD_OFF_CTRL, 32'h0000_0002);
    repeat (60) @(posedge i_mclk);
    wr(LVD_OFF_CTRL, 32'h0000_0003);
    repeat (90) @(posedge i_mclk);
    // shortest cascade, so the narrow delay check sees traffic
    set_cnt(7'h01, 10'h00c);
    repeat (80) @(posedge i_mclk);
    print_verdict();
  end
endmodule
